// ### fsw_regs.vh
`ifndef FSW_REGS_VH
`define FSW_REGS_VH

// status byte layout
`define FSW_STATUS_RESET       8'h00
`define FSW_BIT_SWD            7
`define FSW_BIT_QE             6
`define FSW_BIT_BP_HI          5
`define FSW_BIT_BP_LO          2
`define FSW_BIT_WEL            1
`define FSW_BIT_BUSY           0
`define FSW_NV_RESET           6'h00

// instruction codes handled by this block
`define FSW_WRITE_ENABLE_CMD   8'h06
`define FSW_WRITE_DISABLE_CMD  8'h04
`define FSW_STATUS_WRITE_CMD   8'h01
`define FSW_VOL_STATUS_WE_CMD  8'h50
`define FSW_STATUS_READ_CMD    8'h05
`define FSW_EXT_READ_CMD       8'h81
`define FSW_RESET_ENABLE_CMD   8'h66
`define FSW_RESET_CMD          8'h99
`define FSW_SUSPEND_CMD_A      8'h75
`define FSW_SUSPEND_CMD_B      8'hB0
`define FSW_READ_PARAM_ALT_CMD 8'hC0

// gated array operations
`define FSW_PAGE_PROGRAM_CMD   8'h02
`define FSW_QUAD_PROG_CMD_A    8'h32
`define FSW_QUAD_PROG_CMD_B    8'h38
`define FSW_SECTOR_ERASE_CMD_A 8'hD7
`define FSW_SECTOR_ERASE_CMD_B 8'h20
`define FSW_BLOCK_ERASE_32K    8'h52
`define FSW_BLOCK_ERASE_64K    8'hD8
`define FSW_CHIP_ERASE_CMD_A   8'hC7
`define FSW_CHIP_ERASE_CMD_B   8'h60

// gated register and protection writes
`define FSW_FUNC_REG_WRITE     8'h42
`define FSW_READ_PARAM_NV      8'h65
`define FSW_READ_PARAM_VOL     8'h63
`define FSW_EXT_READ_PARAM_NV  8'h85
`define FSW_EXT_READ_PARAM_VOL 8'h83
`define FSW_INFO_ROW_ERASE     8'h64
`define FSW_INFO_ROW_PROGRAM   8'h62
`define FSW_AUTOBOOT_WRITE     8'h15
`define FSW_DYN_PROTECT_WRITE  8'hFB
`define FSW_PERS_PROTECT_WRITE 8'hFD
`define FSW_PERS_PROTECT_ERASE 8'hE4
`define FSW_PROT_MODE_PROGRAM  8'h2F
`define FSW_PERS_LOCK_WRITE    8'hA6
`define FSW_FREEZE_SET         8'h91
`define FSW_GANG_LOCK          8'h7E
`define FSW_GANG_UNLOCK        8'h98
`define FSW_PASSWORD_PROGRAM   8'hE8

// timing
`define FSW_CLK_MHZ            40
`define FSW_NV_WRITE_US        2000

`endif

// ### fsw_sync.v
// two-stage synchroniser, one chain per bit
module fsw_sync #(
	parameter W = 4
) (
	input  wire         clk,   // sampling clock
	input  wire         rst_n, // async reset, active low
	input  wire [W-1:0] d,     // asynchronous inputs
	output wire [W-1:0] q      // synchronised outputs
);

	////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg meta;
			reg stab;
			// first stage feeds only the second stage
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta <= 1'b1;
					stab <= 1'b1;
				end else begin
					meta <= d[i];
					stab <= meta;
				end
			end
			assign q[i] = stab;
		end
	endgenerate

endmodule // fsw_sync

// ### fsw_nvcell.v
// non-volatile status cells with a timed write
`include "fsw_regs.vh"

module fsw_nvcell #(
	parameter [23:0] CYCLES = 24'h013880
) (
	input  wire       clk,   // core clock
	input  wire       rst_n, // hardware reset, aborts a write in flight
	input  wire       por_n, // power-on reset, factory default only
	input  wire       go,    // one-cycle start of a write
	input  wire [5:0] din,   // bits 7..2 of the status byte
	output wire       busy,  // write cycle running
	output reg  [5:0] q      // stored cells
);

	reg [23:0] cnt;
	reg [5:0]  pend;

	////////////////////////////////////////////////////////////////
	// write timer; data held until the cycle ends
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= 24'h000000;
			pend <= `FSW_NV_RESET;
		end else if (go && cnt == 24'h000000) begin
			cnt  <= CYCLES;
			pend <= din;
		end else if (cnt != 24'h000000) begin
			cnt <= cnt - 24'h000001;
		end
	end

	assign busy = (cnt != 24'h000000);

	// cells keep their value through hardware resets
	always @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			q <= `FSW_NV_RESET;
		end else if (cnt == 24'h000001) begin
			q <= pend;
		end
	end

endmodule // fsw_nvcell

// ### fsw_status.v
// How it works
// - reading the status byte repeats the same byte until chip select rises.
// - after power-up the volatile copy loads from the non-volatile cells.
// - byte is swd, qe, bp3..bp0, wel, busy; all zero by default.
// - bit 0 reads one while an internal write runs, else zero.
// - busy covers program, erase, non-volatile writes and gang lock or unlock.
// - while busy only status reads, resets and suspend are accepted.
// - busy clears when the operation ends, success or not.
// - with the latch clear all write-class operations are inhibited except C0h and a status write armed by 50h.
// - write-enable 06h sets the write enable latch.
// - write-disable clears the write enable latch.
// - latch clears itself when a program, erase or non-volatile register write other than a status write finishes.
// - status writes never alter the write enable latch.
// - status write 01h updates protect, quad and disable bits, both copies, or only the volatile copy when armed by 50h.
// - page, quad page and info row programs need the latch.
// - sector, block, chip and info row erases need the latch.
// - function, read parameter, extended read and autoboot writes need the latch.
// - alternative volatile read parameter write C0h needs no latch.
// - program or erase inside the protected region is refused.
// - quad enable bit turns the quad data function on or off.
// - status write disable marks the status byte as write-protected.
// - chip erase is ignored unless all block protect bits are zero.
// - disable bit set with protect pin low and quad enable clear makes status writes ignored.
// - with quad enable the protect and hold pins become data lines.
`include "fsw_regs.vh"

module fsw_status #(
	parameter NV_WRITE_CYCLES = `FSW_NV_WRITE_US * `FSW_CLK_MHZ
) (
	input  wire        CORE_CLK,   // core clock, 40 MHz
	input  wire        RST_N,      // hardware reset, async, active low
	input  wire        PWR_ON_N,   // power-on reset of the cells, active low
	input  wire        CS_N,       // chip select pin, active low
	input  wire        SCK,        // serial clock pin
	input  wire        SI,         // serial data in pin
	input  wire        WP_N,       // write protect pin, active low
	input  wire        BOTTOM_SEL, // protected area at bottom when high
	input  wire        OP_DONE,    // array engine finished, one-cycle pulse
	output reg         SO,         // serial data out
	output reg         SO_OE_N,    // serial out enable, active low
	output reg         QUAD_EN,    // protect and hold pins act as data lines
	output reg         OP_START,   // start an accepted operation, pulse
	output reg  [7:0]  OP_CODE,    // opcode of the started operation
	output reg  [23:0] OP_ADDR,    // address of the started operation
	output reg  [7:0]  STATUS      // live status byte
);

	localparam ST_LOAD = 1'b0;
	localparam ST_RUN  = 1'b1;
	localparam [23:0] NV_CYC = NV_WRITE_CYCLES[23:0];

	wire [3:0]  pin_s;
	wire        cs_n_s;
	wire        sck_s;
	wire        si_s;
	wire        wp_n_s;
	wire        nv_busy;
	wire [5:0]  nv_q;
	reg         sck_d;
	reg         cs_d;
	reg  [2:0]  bit_cnt;
	reg  [2:0]  byte_idx;
	reg  [7:0]  shreg;
	reg  [7:0]  opcode;
	reg  [23:0] addr;
	reg  [7:0]  wr_data;
	reg         reading;
	reg  [7:0]  out_sh;
	reg         state;
	reg  [5:0]  vol;
	reg         write_enable_latch;
	reg         op_busy;
	reg         op_clr_wel;
	reg         vwe;
	reg         nv_go;

	////////////////////////////////////////////////////////////////
	// pins cross into the core clock before anything looks at them
	fsw_sync #(
		.W (4)
	) u_sync (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.d     ({CS_N, SCK, SI, WP_N}),
		.q     (pin_s)
	);

	assign cs_n_s = pin_s[3];
	assign sck_s  = pin_s[2];
	assign si_s   = pin_s[1];
	assign wp_n_s = pin_s[0];

	// non-volatile half of the protect, quad and disable bits
	fsw_nvcell #(
		.CYCLES (NV_CYC)
	) u_nv (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.por_n (PWR_ON_N),
		.go    (nv_go),
		.din   (wr_data[`FSW_BIT_SWD:`FSW_BIT_BP_LO]),
		.busy  (nv_busy),
		.q     (nv_q)
	);

	////////////////////////////////////////////////////////////////
	// edge finding on the synchronised link signals
	wire sck_rise  = sck_s & ~sck_d;
	wire sck_fall  = ~sck_s & sck_d;
	wire cs_rise   = cs_n_s & ~cs_d;
	wire byte_done = sck_rise && !cs_n_s && bit_cnt == 3'h7;
	wire [7:0] new_byte = {shreg[6:0], si_s};

	wire busy_now = op_busy | nv_busy;
	wire [7:0] status_now = {vol, write_enable_latch, busy_now};
	wire [3:0] bp = vol[`FSW_BIT_BP_HI-2:`FSW_BIT_BP_LO-2];

	// protect pin only counts while it is not a data line
	wire sw_locked = vol[`FSW_BIT_SWD-2] & ~wp_n_s & ~vol[`FSW_BIT_QE-2];

	// only whole bytes make a command; a torn frame is dropped
	wire cmd_whole = byte_idx != 3'h0 && bit_cnt == 3'h0;

	////////////////////////////////////////////////////////////////
	// opcodes that need the write enable latch
	function gated;
		input [7:0] op;
		begin
			case (op)
				`FSW_PAGE_PROGRAM_CMD, `FSW_QUAD_PROG_CMD_A,
				`FSW_QUAD_PROG_CMD_B, `FSW_INFO_ROW_PROGRAM: gated = 1'b1;
				`FSW_SECTOR_ERASE_CMD_A, `FSW_SECTOR_ERASE_CMD_B,
				`FSW_BLOCK_ERASE_32K, `FSW_BLOCK_ERASE_64K,
				`FSW_CHIP_ERASE_CMD_A, `FSW_CHIP_ERASE_CMD_B,
				`FSW_INFO_ROW_ERASE: gated = 1'b1;
				`FSW_FUNC_REG_WRITE, `FSW_READ_PARAM_NV,
				`FSW_READ_PARAM_VOL, `FSW_EXT_READ_PARAM_NV,
				`FSW_EXT_READ_PARAM_VOL, `FSW_AUTOBOOT_WRITE: gated = 1'b1;
				`FSW_DYN_PROTECT_WRITE, `FSW_PERS_PROTECT_WRITE,
				`FSW_PERS_PROTECT_ERASE, `FSW_PROT_MODE_PROGRAM,
				`FSW_PERS_LOCK_WRITE, `FSW_FREEZE_SET,
				`FSW_GANG_LOCK, `FSW_GANG_UNLOCK,
				`FSW_PASSWORD_PROGRAM: gated = 1'b1;
				default: gated = 1'b0;
			endcase
		end
	endfunction

	// volatile register writes run without a busy phase
	function volatile_only;
		input [7:0] op;
		begin
			volatile_only = (op == `FSW_READ_PARAM_VOL) ||
				(op == `FSW_EXT_READ_PARAM_VOL) ||
				(op == `FSW_READ_PARAM_ALT_CMD);
		end
	endfunction

	// operations that touch the array and so obey block protection
	function array_op;
		input [7:0] op;
		begin
			case (op)
				`FSW_PAGE_PROGRAM_CMD, `FSW_QUAD_PROG_CMD_A,
				`FSW_QUAD_PROG_CMD_B, `FSW_SECTOR_ERASE_CMD_A,
				`FSW_SECTOR_ERASE_CMD_B, `FSW_BLOCK_ERASE_32K,
				`FSW_BLOCK_ERASE_64K: array_op = 1'b1;
				default: array_op = 1'b0;
			endcase
		end
	endfunction

	// the short list honoured while a write cycle runs
	function busy_ok;
		input [7:0] op;
		begin
			case (op)
				`FSW_STATUS_READ_CMD, `FSW_EXT_READ_CMD,
				`FSW_RESET_ENABLE_CMD, `FSW_RESET_CMD,
				`FSW_SUSPEND_CMD_A, `FSW_SUSPEND_CMD_B: busy_ok = 1'b1;
				default: busy_ok = 1'b0;
			endcase
		end
	endfunction

	// 64 KB block covered by the protect setting; 1, 2, 4 .. 64 blocks, or all 128 with bp3 set
	function in_prot;
		input [3:0] b;
		input       bottom;
		input [6:0] blk;
		reg   [7:0] size;
		begin
			size = 8'h01 << (b[2:0] - 3'h1);
			if (b == 4'h0)
				in_prot = 1'b0;
			else if (b[3])
				in_prot = 1'b1;
			else if (bottom)
				in_prot = {1'b0, blk} < size;
			else
				in_prot = {1'b0, blk} >= (8'h80 - size);
		end
	endfunction

	wire chip_erase = opcode == `FSW_CHIP_ERASE_CMD_A || opcode == `FSW_CHIP_ERASE_CMD_B;
	wire prot_hit   = array_op(opcode) && in_prot(bp, BOTTOM_SEL, addr[22:16]);
	wire chip_block = chip_erase && bp != 4'h0;

	////////////////////////////////////////////////////////////////
	// serial receive: opcode, then three address bytes; the first address byte doubles as the data byte
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sck_d    <= 1'b1; // matches the synchroniser's reset level, no false rising edge
			cs_d     <= 1'b1;
			bit_cnt  <= 3'h0;
			byte_idx <= 3'h0;
			shreg    <= 8'h00;
			opcode   <= 8'h00;
			addr     <= 24'h000000;
			wr_data  <= 8'h00;
		end else begin
			sck_d <= sck_s;
			cs_d  <= cs_n_s;
			if (cs_n_s) begin
				bit_cnt  <= 3'h0;
				byte_idx <= 3'h0;
			end else if (sck_rise) begin
				bit_cnt <= bit_cnt + 3'h1;
				shreg   <= new_byte;
				if (byte_done) begin
					if (byte_idx != 3'h7)
						byte_idx <= byte_idx + 3'h1;
					case (byte_idx)
						3'h0: opcode <= new_byte;
						3'h1: begin
							addr[23:16] <= new_byte;
							wr_data     <= new_byte;
						end
						3'h2: addr[15:8] <= new_byte;
						3'h3: addr[7:0]  <= new_byte;
						default: ;
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// status read: snapshot once, rotate so the byte repeats forever
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			reading <= 1'b0;
			out_sh  <= `FSW_STATUS_RESET;
			SO      <= 1'b0;
			SO_OE_N <= 1'b1;
		end else begin
			if (cs_n_s) begin
				reading <= 1'b0;
				SO_OE_N <= 1'b1;
			end else if (byte_done && byte_idx == 3'h0 &&
				new_byte == `FSW_STATUS_READ_CMD) begin
				reading <= 1'b1;
				out_sh  <= status_now;
			end else if (reading && sck_fall) begin
				SO      <= out_sh[7];
				SO_OE_N <= 1'b0;
				out_sh  <= {out_sh[6:0], out_sh[7]};
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// command commit at the end of the frame
	// operation busy ends on the engine's done pulse, status write busy on the cell timer; commands outside busy_ok are dropped until then
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state      <= ST_LOAD;
			vol        <= `FSW_NV_RESET;
			write_enable_latch        <= 1'b0;
			op_busy    <= 1'b0;
			op_clr_wel <= 1'b0;
			vwe        <= 1'b0;
			nv_go      <= 1'b0;
			OP_START   <= 1'b0;
			OP_CODE    <= 8'h00;
			OP_ADDR    <= 24'h000000;
		end else begin
			OP_START <= 1'b0;
			nv_go    <= 1'b0;
			case (state)
				ST_LOAD: begin
					vol   <= nv_q;
					state <= ST_RUN;
				end
				ST_RUN: begin
					if (OP_DONE && op_busy) begin
						op_busy <= 1'b0;
						if (op_clr_wel)
							write_enable_latch <= 1'b0;
					end
					if (cs_rise && cmd_whole && (!busy_now || busy_ok(opcode))) begin
						case (opcode)
							`FSW_WRITE_ENABLE_CMD: begin
								write_enable_latch <= 1'b1;
								vwe <= 1'b0;
							end
							`FSW_WRITE_DISABLE_CMD: begin
								write_enable_latch <= 1'b0;
								vwe <= 1'b0;
							end
							`FSW_VOL_STATUS_WE_CMD: vwe <= 1'b1;
							`FSW_STATUS_WRITE_CMD: begin
								// latch untouched on either path
								vwe <= 1'b0;
								if (byte_idx >= 3'h2 && !sw_locked) begin
									if (vwe) begin
										vol <= wr_data[7:2];
									end else if (write_enable_latch) begin
										vol   <= wr_data[7:2];
										nv_go <= 1'b1;
									end
								end
							end
							`FSW_READ_PARAM_ALT_CMD, `FSW_RESET_ENABLE_CMD,
							`FSW_RESET_CMD, `FSW_SUSPEND_CMD_A,
							`FSW_SUSPEND_CMD_B: begin
								vwe      <= 1'b0;
								OP_START <= 1'b1;
								OP_CODE  <= opcode;
								OP_ADDR  <= addr;
							end
							default: begin
								vwe <= 1'b0;
								if (gated(opcode) && write_enable_latch && !prot_hit && !chip_block) begin
									OP_START <= 1'b1;
									OP_CODE  <= opcode;
									OP_ADDR  <= addr;
									if (!volatile_only(opcode)) begin
										op_busy    <= 1'b1;
										op_clr_wel <= 1'b1;
									end
								end
							end
						endcase
					end
				end
				default: state <= ST_LOAD;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// registered views of the live state
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			STATUS  <= `FSW_STATUS_RESET;
			QUAD_EN <= 1'b0;
		end else begin
			STATUS  <= status_now;
			QUAD_EN <= vol[`FSW_BIT_QE-2];
		end
	end

endmodule // fsw_status

// ### fsw_host.sv
// host controller model: mode 0 frames, clock idle low and still between frames
module fsw_host (
	input  wire logic clk,  // core clock, paces the serial clock
	output logic      cs_n, // chip select, active low
	output logic      sck,  // serial clock, 200 ns period inside frames
	output logic      si,   // serial data to the device
	input  wire logic so    // serial data from the device
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus at time zero
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one frame of nbits taken msb first from tx; rx keeps the last 16 bits read back
	// so is sampled just before the next fall, the device updates it only after a fall
	task automatic frame(input logic [31:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge clk);
		cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			si = tx[31-i];
			repeat (4) @(negedge clk);
			sck = 1'b1;
			repeat (4) @(negedge clk);
			if (i >= 8) begin
				rx = {rx[14:0], so};
			end
			sck = 1'b0;
		end
		repeat (4) @(negedge clk);
		cs_n = 1'b1; // whole frame ends with chip select high, gap follows
		si   = ~si;  // released data line does not keep its last level
		repeat (8) @(negedge clk);
	endtask
endmodule // fsw_host

// ### fsw_status_checker.sv
module fsw_chk #(
	parameter NV_WRITE_CYCLES = 80000
) (
	input wire       CORE_CLK, // core clock
	input wire       RST_N,    // reset, active low
	input wire       CS_N,     // chip select pin
	input wire       OP_DONE,  // engine done pulse
	input wire       SO_OE_N,  // serial out enable, active low
	input wire       QUAD_EN,  // quad data lines enabled
	input wire       OP_START, // operation start pulse
	input wire [7:0] OP_CODE,  // opcode of last start
	input wire [7:0] STATUS    // live status byte
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	reg  [31:0] busy_len;
	// last start that keeps busy until the engine answers
	wire        arr_code = OP_CODE inside {8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52,
		8'hD8, 8'hC7, 8'h60};
	// last start cannot hold busy itself, so busy comes from a status write
	wire        quiet_code = OP_CODE inside {8'h00, 8'hC0, 8'h63, 8'h83};
	wire        gated = arr_code || (OP_CODE inside {8'h42, 8'h65, 8'h63, 8'h85, 8'h83,
		8'h64, 8'h62, 8'h15});

	// busy run length, zero while ready
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			busy_len <= 32'h0;
		end else begin
			busy_len <= STATUS[0] ? busy_len + 32'h1 : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_gate_latch: assert property (OP_START && gated |-> STATUS[1])
		else $error("gated operation started without write enable");
	a_chip_erase_bp: assert property (OP_START && (OP_CODE inside {8'hC7, 8'h60}) |->
		STATUS[5:2] == 4'h0) else $error("chip erase started with protection set");
	a_busy_discard: assert property (OP_START && STATUS[0] |->
		OP_CODE inside {8'h05, 8'h81, 8'h66, 8'h99, 8'h75, 8'hB0})
		else $error("instruction accepted while busy");
	a_busy_start: assert property (OP_START && arr_code |-> ##[0:2] STATUS[0])
		else $error("busy not raised by array operation");
	a_done_clear: assert property (OP_DONE && STATUS[0] && arr_code |->
		##[1:2] STATUS[1:0] == 2'b00) else $error("busy or latch kept after completion");
	// engine completion may clear the latch mid-frame; commits land 3 cycles after the rise
	a_commit_cs: assert property ($changed(STATUS[7:1]) && !$past(OP_DONE, 2) |->
		$past(CS_N, 3))
		else $error("status changed inside a frame");
	a_so_release: assert property ($rose(CS_N) |-> ##[1:6] SO_OE_N)
		else $error("serial out still driven after deselect");
	a_quad_copy: assert property (QUAD_EN != STATUS[6] |=> QUAD_EN == STATUS[6])
		else $error("quad enable output differs from status");
	a_nv_busy_len: assert property ($fell(STATUS[0]) && quiet_code |->
		busy_len >= NV_WRITE_CYCLES - 1 && busy_len <= NV_WRITE_CYCLES + 1)
		else $error("status write busy time wrong");
endmodule // fsw_chk

bind fsw_status fsw_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk_u (.CORE_CLK(CORE_CLK),
	.RST_N(RST_N), .CS_N(CS_N), .OP_DONE(OP_DONE), .SO_OE_N(SO_OE_N), .QUAD_EN(QUAD_EN),
	.OP_START(OP_START), .OP_CODE(OP_CODE), .STATUS(STATUS));

// ### fsw_status_test.sv
module fsw_status_test;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		logic [31:0] tx;  // frame bits, msb first
		int          nb;  // bits in the frame
		logic        dn;  // engine must answer
		logic        st;  // start expected
		logic [7:0]  exp; // status afterwards
	} fsw_row_t;

	localparam int NVW = 20; // short status write time for simulation
	localparam logic [7:0] GATED [26] = '{8'h02, 8'h32, 8'h38, 8'hD7, 8'h20, 8'h52, 8'hD8,
		8'hC7, 8'h60, 8'h42, 8'h65, 8'h63, 8'h85, 8'h83, 8'h64, 8'h62, 8'h15, 8'hFB, 8'hFD,
		8'hE4, 8'h2F, 8'hA6, 8'h91, 8'h7E, 8'h98, 8'hE8};
	fsw_row_t rows [15] = '{
		'{32'h06000000, 8, 0, 0, 8'h02},
		'{32'h04000000, 8, 0, 0, 8'h00},
		'{32'hD8000000, 32, 0, 0, 8'h00},
		'{32'h06000000, 8, 0, 0, 8'h02},
		'{32'h010C0000, 16, 0, 0, 8'h0E},
		'{32'hD87F0000, 32, 0, 0, 8'h0E},
		'{32'hC7000000, 8, 0, 0, 8'h0E},
		'{32'hD8000000, 32, 1, 1, 8'h0C},
		'{32'h06000000, 8, 0, 0, 8'h0E},
		'{32'h01400000, 16, 0, 0, 8'h42},
		'{32'h02010000, 32, 1, 1, 8'h40},
		'{32'hC0000000, 16, 0, 1, 8'h40},
		'{32'h63000000, 16, 0, 0, 8'h40},
		'{32'h06000000, 8, 0, 0, 8'h42},
		'{32'hC7000000, 8, 1, 1, 8'h40}
	};

	logic        core_clk;
	logic        rst_n;
	logic        pwr_on_n;
	logic        wp_n;
	logic        bottom_sel;
	logic        op_done;
	logic        saw_start;
	logic [15:0] rx;
	wire         cs_n, sck, si, so, so_oe_n, quad_en, op_start;
	wire  [7:0]  op_code, status;
	wire  [23:0] op_addr;
	int          n_errors;
	int          n_tests;

	fsw_host host_u (.clk(core_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so));
	fsw_status #(.NV_WRITE_CYCLES(NVW)) dut_u (.CORE_CLK(core_clk), .RST_N(rst_n),
		.PWR_ON_N(pwr_on_n), .CS_N(cs_n), .SCK(sck), .SI(si), .WP_N(wp_n),
		.BOTTOM_SEL(bottom_sel), .OP_DONE(op_done), .SO(so), .SO_OE_N(so_oe_n),
		.QUAD_EN(quad_en), .OP_START(op_start), .OP_CODE(op_code), .OP_ADDR(op_addr),
		.STATUS(status));

	// 40 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// start pulses are caught here, send clears the flag before each frame it sends
	always @(posedge core_clk) begin
		if (op_start === 1'b1) saw_start <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_flag(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	// reads the byte twice in one frame: a snapshot must simply repeat
	task automatic rd_status(input logic [7:0] exp);
		host_u.frame(32'h05000000, 24, rx);
		chk_byte("status byte", exp, rx[15:8]);
		chk_byte("status repeat", exp, rx[7:0]);
	endtask

	task automatic send(input logic [31:0] tx, input int nb);
		saw_start = 1'b0;
		host_u.frame(tx, nb, rx);
	endtask

	// engine answers late on purpose, then wait for ready under a bound
	task automatic finish_op;
		repeat (10) @(negedge core_clk);
		op_done = 1'b1;
		@(negedge core_clk);
		op_done = 1'b0;
	endtask

	task automatic wait_ready;
		int k;
		for (k = 0; k < 100 && status[0] !== 1'b0; k++) @(negedge core_clk);
		if (k == 100) begin
			n_errors++;
			test_done();
		end
	endtask

	task automatic do_reset(input logic cells);
		@(negedge core_clk);
		rst_n    = 1'b0;
		pwr_on_n = ~cells;
		repeat (2) @(negedge core_clk);
		rst_n    = 1'b1;
		pwr_on_n = 1'b1;
		repeat (4) @(negedge core_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// hang guard
	initial begin
		repeat (100000) @(posedge core_clk);
		n_errors++;
		test_done();
	end

	// main sequence
	initial begin
		n_errors   = 0;
		n_tests    = 0;
		rst_n      = 1'b0;
		pwr_on_n   = 1'b0;
		wp_n       = 1'b1;
		bottom_sel = 1'b0;
		op_done    = 1'b0;
		saw_start  = 1'b0;
		do_reset(1'b1);
		rd_status(8'h00);
		foreach (rows[i]) begin
			send(rows[i].tx, rows[i].nb);
			chk_flag("op start", rows[i].st, saw_start);
			if (rows[i].st) chk_byte("op code", rows[i].tx[31:24], op_code);
			if (rows[i].dn) finish_op();
			wait_ready();
			rd_status(rows[i].exp);
			chk_flag("quad enable", rows[i].exp[6], quad_en);
		end
		// every gated opcode with the latch clear
		foreach (GATED[i]) begin
			send({GATED[i], 24'h000000}, 32);
			chk_flag("gated start", 1'b0, saw_start);
		end
		rd_status(8'h40);
		// opcode cut short by one bit
		send(32'h06000000, 7);
		rd_status(8'h40);
		// instructions during a running erase
		send(32'h06000000, 8);
		send(32'hD8000000, 32);
		send(32'h04000000, 8);
		send(32'h75000000, 8);
		chk_flag("suspend start", 1'b1, saw_start);
		chk_byte("suspend code", 8'h75, op_code);
		rd_status(8'h43);
		finish_op();
		wait_ready();
		rd_status(8'h40);
		// hardware write protection of the status byte
		send(32'h06000000, 8);
		send(32'h01800000, 16);
		wait_ready();
		rd_status(8'h82);
		wp_n = 1'b0;
		send(32'h01000000, 16);
		rd_status(8'h82);
		wp_n = 1'b1;
		send(32'h01340000, 16);
		wait_ready();
		rd_status(8'h36);
		// quad enable frees the protect pin from its lock role
		send(32'h01C00000, 16);
		wait_ready();
		rd_status(8'hC2);
		wp_n = 1'b0;
		send(32'h01340000, 16);
		wait_ready();
		rd_status(8'h36);
		wp_n = 1'b1;
		// armed volatile write skips the cells and keeps the latch
		send(32'h50000000, 8);
		send(32'h01000000, 16);
		rd_status(8'h02);
		// volatile copy reloads from the cells, latch does not survive
		do_reset(1'b0);
		rd_status(8'h34);
		do_reset(1'b1);
		rd_status(8'h00);
		test_done();
	end
endmodule // fsw_status_test
